// ### rtl/dsam_top.sv
// Dword synchronization acquire and monitor: receiver plus sync state machine.
// Assumes decoded characters in, messages to and from a phy reset sequencer,
// and a link layer that takes forwarded dwords without back-pressure.
//
// Functional notes
// - On find, commas go to slot one; comma plus three clean data is primitive.
// - Commas are accepted with either running disparity.
// - Once aligned, every four characters are classed invalid, primitive or data.
// - Received dword indications also go toward the link layer.
// - Reset, management reset, disable or halt message put the machine in acquire.
// - In acquire, a begin message issues find and loads the 1 ms timer.
// - Re-entering acquire from valid states reissues find without reloading timer.
// - Timeout reset message only after the timer expires, and optional then.
// - Acquire advances only after find issued and a primitive then received.
// - Valid states return to acquire on invalid dword or timer expiry.
// - Each primitive advances valid states; three primitives reach locked.
// - On lock, forward the completing primitive and every later dword except the one that ends sync.
// - Withhold dwords from the link layer while not synchronized.
// - In locked, an invalid dword moves to the first lost state.
// - Each invalid dword needs two valid ones to cancel; four uncancelled lose sync.
// - In first lost, a valid dword moves to first recovered.
// - Recovered states step back on valid, step deeper on invalid.
// - Fourth uncancelled invalid dword signals sync loss and returns to acquire.
`timescale 1ns/1ps
module dsam_top #(
  parameter int TIMEOUT_CYC = dsam_pkg::TIMEOUT_CYC
) (
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic                 char_valid_i,
  input  wire logic [7:0]           char_i,
  input  wire logic                 char_k_i,
  input  wire logic                 char_code_err_i,
  input  wire logic                 char_disp_err_i,
  input  wire logic                 sync_begin_msg_i,
  input  wire logic                 sync_halt_msg_i,
  input  wire logic                 mgmt_reset_req_i,
  input  wire logic                 disable_phy_req_i,
  output logic                      sync_lost_msg_o,
  output logic                      sync_timeout_reset_msg_o,
  output logic                      sync_locked_o,
  output logic                      link_dw_valid_o,
  output logic [31:0]               link_dw_o,
  output logic [3:0]                link_dw_k_o,
  output dsam_pkg::dsam_class_t     link_dw_class_o
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TIMER_LOAD = TW'(TIMEOUT_CYC);

  dsam_pkg::dsam_state_t dword_sync_fsm, next_state;
  logic                  armed, next_armed;
  logic                  find_req, next_find;
  logic [TW-1:0]         acquire_timeout_timer, next_timer;
  logic                  timer_run, next_timer_run;
  logic                  reset_sent, next_reset_sent;
  logic                  next_lost, next_treset, next_locked;
  logic                  next_link_valid;
  logic [31:0]           next_link_dw;
  logic [3:0]            next_link_k;
  dsam_pkg::dsam_class_t next_link_class;
  logic                  dw_valid;
  logic [31:0]           dw;
  logic [3:0]            dw_k;
  dsam_pkg::dsam_class_t dw_class;
  logic                  accept, is_bad, is_good, is_prim, timer_expired, leave;

  // The receiver acts on the find pulse at the edge after the one that raises it.
  dsam_char_rx dsam_char_rx_i (
    .clock_i         (clock_i),
    .srst_i          (srst_i),
    .char_valid_i    (char_valid_i),
    .char_i          (char_i),
    .char_k_i        (char_k_i),
    .char_code_err_i (char_code_err_i),
    .char_disp_err_i (char_disp_err_i),
    .find_i          (find_req),
    .dw_valid_o      (dw_valid),
    .dw_o            (dw),
    .dw_k_o          (dw_k),
    .dw_class_o      (dw_class)
  );

  // A dword shown while find is high was classed under the old alignment,
  // so it is dropped; this is what makes a primitive count only after find.
  assign accept        = dw_valid && !find_req;
  assign is_bad        = accept && dw_class == dsam_pkg::CL_INVALID;
  assign is_good       = accept && dw_class != dsam_pkg::CL_INVALID;
  assign is_prim       = accept && dw_class == dsam_pkg::CL_PRIM;
  assign timer_expired = timer_run && acquire_timeout_timer == '0;
  assign leave         = srst_i || mgmt_reset_req_i || disable_phy_req_i || sync_halt_msg_i;

  // Next-state logic for the sync machine, its timer and its messages.
  always_comb begin
    next_state      = dword_sync_fsm;
    next_armed      = armed;
    next_find       = 1'b0;
    next_timer      = acquire_timeout_timer;
    next_timer_run  = timer_run;
    next_reset_sent = reset_sent;
    next_lost       = 1'b0;
    next_treset     = 1'b0;
    next_link_valid = 1'b0;
    next_link_dw    = link_dw_o;
    next_link_k     = link_dw_k_o;
    next_link_class = link_dw_class_o;
    // The timer counts down and holds at zero once expired.
    if (timer_run && acquire_timeout_timer != '0)
      next_timer = acquire_timeout_timer - TW'(1);
    // Forwarding is gated by sync; the completing primitive is let through too.
    if (accept && (dsam_pkg::in_sync(dword_sync_fsm) ||
        (dword_sync_fsm == dsam_pkg::second_valid_state && is_prim &&
         !timer_expired))) begin
      next_link_valid = 1'b1;
      next_link_dw    = dw;
      next_link_k     = dw_k;
      next_link_class = dw_class;
    end
    case (dword_sync_fsm)
      dsam_pkg::acquire_state: begin
        if (sync_begin_msg_i) begin
          next_find       = 1'b1;
          next_armed      = 1'b1;
          next_timer      = TIMER_LOAD;
          next_timer_run  = 1'b1;
          next_reset_sent = 1'b0;
        end else if (armed && is_prim) begin
          next_state = dsam_pkg::first_valid_state;
        end else if (timer_expired && !reset_sent) begin
          // Timed out while hunting: ask for a fresh link reset once.
          next_treset     = 1'b1;
          next_reset_sent = 1'b1;
        end
      end
      dsam_pkg::first_valid_state,
      dsam_pkg::second_valid_state: begin
        if (is_bad || timer_expired) begin
          next_state = dsam_pkg::acquire_state;
          next_find  = 1'b1;
        end else if (is_prim) begin
          next_state = (dword_sync_fsm == dsam_pkg::first_valid_state) ?
                       dsam_pkg::second_valid_state : dsam_pkg::locked_state;
          if (dword_sync_fsm == dsam_pkg::second_valid_state)
            next_timer_run = 1'b0;
        end
      end
      dsam_pkg::locked_state: begin
        if (is_bad)
          next_state = dsam_pkg::first_lost_state;
      end
      // Each invalid dword goes one level deeper; two valid ones undo it.
      dsam_pkg::first_lost_state: begin
        if (is_good)
          next_state = dsam_pkg::first_recovered_state;
        else if (is_bad)
          next_state = dsam_pkg::second_lost_state;
      end
      dsam_pkg::first_recovered_state: begin
        if (is_good)
          next_state = dsam_pkg::locked_state;
        else if (is_bad)
          next_state = dsam_pkg::second_lost_state;
      end
      dsam_pkg::second_lost_state: begin
        if (is_good)
          next_state = dsam_pkg::second_recovered_state;
        else if (is_bad)
          next_state = dsam_pkg::third_lost_state;
      end
      dsam_pkg::second_recovered_state: begin
        if (is_good)
          next_state = dsam_pkg::first_lost_state;
        else if (is_bad)
          next_state = dsam_pkg::third_lost_state;
      end
      dsam_pkg::third_lost_state,
      dsam_pkg::third_recovered_state: begin
        if (is_bad) begin
          // Fourth uncancelled invalid dword: sync is gone.
          next_state      = dsam_pkg::acquire_state;
          next_lost       = 1'b1;
          next_armed      = 1'b0;
          next_link_valid = 1'b0;
        end else if (is_good) begin
          next_state = (dword_sync_fsm == dsam_pkg::third_lost_state) ?
                       dsam_pkg::third_recovered_state : dsam_pkg::second_lost_state;
        end
      end
      default: next_state = dsam_pkg::acquire_state;
    endcase
    // External stops override everything and leave the machine idle.
    if (sync_halt_msg_i || mgmt_reset_req_i || disable_phy_req_i) begin
      next_state      = dsam_pkg::acquire_state;
      next_armed      = 1'b0;
      next_find       = 1'b0;
      next_timer_run  = 1'b0;
      next_lost       = 1'b0;
      next_treset     = 1'b0;
      next_link_valid = 1'b0;
    end
    next_locked = dsam_pkg::in_sync(next_state);
  end

  // Registers only; synchronous reset also lands in the acquire state.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dword_sync_fsm           <= dsam_pkg::acquire_state;
      armed                    <= 1'b0;
      find_req                 <= 1'b0;
      acquire_timeout_timer    <= '0;
      timer_run                <= 1'b0;
      reset_sent               <= 1'b0;
      sync_lost_msg_o          <= 1'b0;
      sync_timeout_reset_msg_o <= 1'b0;
      sync_locked_o            <= 1'b0;
      link_dw_valid_o          <= 1'b0;
      link_dw_o                <= 32'h00000000;
      link_dw_k_o              <= 4'h0;
      link_dw_class_o          <= dsam_pkg::CL_INVALID;
    end else begin
      dword_sync_fsm           <= next_state;
      armed                    <= next_armed;
      find_req                 <= next_find;
      acquire_timeout_timer    <= next_timer;
      timer_run                <= next_timer_run;
      reset_sent               <= next_reset_sent;
      sync_lost_msg_o          <= next_lost;
      sync_timeout_reset_msg_o <= next_treset;
      sync_locked_o            <= next_locked;
      link_dw_valid_o          <= next_link_valid;
      link_dw_o                <= next_link_dw;
      link_dw_k_o              <= next_link_k;
      link_dw_class_o          <= next_link_class;
    end
  end

  default clocking dsam_cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_halt_idle;
    sync_halt_msg_i || mgmt_reset_req_i || disable_phy_req_i |=>
      dword_sync_fsm == dsam_pkg::acquire_state && !armed && !timer_run;
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("stop did not idle");

  property p_begin_loads;
    dword_sync_fsm == dsam_pkg::acquire_state && sync_begin_msg_i && !leave |=>
      find_req && acquire_timeout_timer == TIMER_LOAD;
  endproperty
  a_begin_loads: assert property (p_begin_loads) else $error("begin without find or load");

  property p_refind_keeps_timer;
    (dword_sync_fsm == dsam_pkg::first_valid_state ||
     dword_sync_fsm == dsam_pkg::second_valid_state) && is_bad && !leave &&
     acquire_timeout_timer > TW'(2) |=>
      find_req && acquire_timeout_timer == $past(acquire_timeout_timer) - TW'(1);
  endproperty
  a_refind_keeps_timer: assert property (p_refind_keeps_timer) else $error("timer reloaded");

  property p_reset_after_expiry;
    sync_timeout_reset_msg_o |-> $past(timer_expired) && reset_sent;
  endproperty
  a_reset_after_expiry: assert property (p_reset_after_expiry) else $error("early reset");

  property p_invalid_aborts;
    (dword_sync_fsm == dsam_pkg::first_valid_state ||
     dword_sync_fsm == dsam_pkg::second_valid_state) && (is_bad || timer_expired) && !leave
      |=> dword_sync_fsm == dsam_pkg::acquire_state;
  endproperty
  a_invalid_aborts: assert property (p_invalid_aborts) else $error("valid state held");

  property p_lock_path;
    dword_sync_fsm == dsam_pkg::locked_state && $changed(dword_sync_fsm) |->
      $past(dword_sync_fsm) == dsam_pkg::second_valid_state ||
      $past(dword_sync_fsm) == dsam_pkg::first_recovered_state;
  endproperty
  a_lock_path: assert property (p_lock_path) else $error("lock entered wrongly");

  property p_withhold;
    link_dw_valid_o |-> sync_locked_o;
  endproperty
  a_withhold: assert property (p_withhold) else $error("dword forwarded out of sync");

  property p_lock_forwards;
    dword_sync_fsm == dsam_pkg::second_valid_state && is_prim && !leave && !timer_expired |=>
      link_dw_valid_o && link_dw_class_o == dsam_pkg::CL_PRIM;
  endproperty
  a_lock_forwards: assert property (p_lock_forwards) else $error("completing prim lost");

  property p_first_loss;
    dword_sync_fsm == dsam_pkg::locked_state && is_bad && !leave |=>
      dword_sync_fsm == dsam_pkg::first_lost_state;
  endproperty
  a_first_loss: assert property (p_first_loss) else $error("invalid ignored");

  property p_recover;
    dword_sync_fsm == dsam_pkg::first_lost_state && is_good && !leave |=>
      dword_sync_fsm == dsam_pkg::first_recovered_state ##1
      (dword_sync_fsm != dsam_pkg::third_lost_state);
  endproperty
  a_recover: assert property (p_recover) else $error("no recovery");

  property p_loss_msg;
    sync_lost_msg_o |-> !sync_locked_o && $past(is_bad) &&
      ($past(dword_sync_fsm) == dsam_pkg::third_lost_state ||
       $past(dword_sync_fsm) == dsam_pkg::third_recovered_state);
  endproperty
  a_loss_msg: assert property (p_loss_msg) else $error("loss message misplaced");

  property p_pulses;
    sync_lost_msg_o || sync_timeout_reset_msg_o |=>
      !sync_lost_msg_o && !sync_timeout_reset_msg_o;
  endproperty
  a_pulses: assert property (p_pulses) else $error("message longer than a cycle");

  c_lock: cover property (dword_sync_fsm == dsam_pkg::locked_state);
  c_loss: cover property (sync_lost_msg_o);
  c_timeout: cover property (sync_timeout_reset_msg_o);
  c_relock: cover property (dword_sync_fsm == dsam_pkg::first_recovered_state ##1
                            dword_sync_fsm == dsam_pkg::locked_state);

endmodule : dsam_top

// ### rtl/dsam_pkg.sv
// Shared constants, types and helpers for the dword sync acquire and monitor block.
// Assumes characters arrive already 8b/10b decoded, one per clock at most.
package dsam_pkg;

  // Control character used as the dword comma; it leads every primitive.
  localparam logic [7:0] COMMA_CHAR = 8'hBC;

  // Acquisition timeout, in its own unit, and the clock period.
  localparam int TIMEOUT_NS   = 1000000;
  localparam int CLK_NS       = 40;
  // A longest wait rounds down to whole cycles.
  localparam int TIMEOUT_CYC  = TIMEOUT_NS / CLK_NS;

  // Index of the last character slot in a dword.
  localparam logic [1:0] LAST_SLOT = 2'h3;

  // Classification of each received dword.
  typedef enum logic [1:0] {
    CL_INVALID,
    CL_PRIM,
    CL_DATA
  } dsam_class_t;

  // States of the dword synchronization machine.
  typedef enum logic [3:0] {
    acquire_state,
    first_valid_state,
    second_valid_state,
    locked_state,
    first_lost_state,
    first_recovered_state,
    second_lost_state,
    second_recovered_state,
    third_lost_state,
    third_recovered_state
  } dsam_state_t;

  // A comma is the control character whatever disparity it came with.
  function automatic logic is_comma(input logic [7:0] ch, input logic is_k);
    is_comma = is_k && (ch == COMMA_CHAR);
  endfunction : is_comma

  // States in which dword synchronization is held.
  function automatic logic in_sync(input dsam_state_t st);
    in_sync = (st != acquire_state) && (st != first_valid_state) &&
              (st != second_valid_state);
  endfunction : in_sync

endpackage : dsam_pkg

// ### rtl/dsam_char_rx.sv
// Character receiver: aligns the decoded stream on commas and classifies dwords.
// Assumes one decoded character per char_valid_i cycle, with decode and disparity flags.
`timescale 1ns/1ps
module dsam_char_rx (
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic                 char_valid_i,
  input  wire logic [7:0]           char_i,
  input  wire logic                 char_k_i,
  input  wire logic                 char_code_err_i,
  input  wire logic                 char_disp_err_i,
  input  wire logic                 find_i,
  output logic                      dw_valid_o,
  output logic [31:0]               dw_o,
  output logic [3:0]                dw_k_o,
  output dsam_pkg::dsam_class_t     dw_class_o
);

  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_ALIGNED} dsam_rx_t;

  dsam_rx_t              mode, next_mode;
  logic [1:0]            slot, next_slot;
  logic [31:0]           acc, next_acc;
  logic [3:0]            kacc, next_kacc;
  logic                  bad, next_bad;
  logic                  next_dw_valid;
  logic [31:0]           next_dw;
  logic [3:0]            next_dw_k;
  dsam_pkg::dsam_class_t next_dw_class;

  // Alignment and classification; a find request drops any partial dword.
  always_comb begin
    logic        chr_ok;
    logic [31:0] full;
    logic [3:0]  kfull;
    chr_ok        = !char_code_err_i && !char_disp_err_i;
    full          = {acc[23:0], char_i};
    kfull         = {kacc[2:0], char_k_i};
    next_mode     = mode;
    next_slot     = slot;
    next_acc      = acc;
    next_kacc     = kacc;
    next_bad      = bad;
    next_dw_valid = 1'b0;
    next_dw       = dw_o;
    next_dw_k     = dw_k_o;
    next_dw_class = dw_class_o;
    if (find_i) begin
      next_mode = RX_HUNT;
      next_slot = 2'h0;
    end else if (char_valid_i) begin
      case (mode)
        RX_HUNT: begin
          // Any comma without a code error restarts a candidate dword in the first slot.
          if (dsam_pkg::is_comma(char_i, char_k_i) && !char_code_err_i) begin
            next_slot = 2'h1;
            next_acc  = {24'h000000, char_i};
            next_kacc = 4'h1;
          end else if (slot != 2'h0 && !char_k_i && chr_ok) begin
            next_acc  = full;
            next_kacc = kfull;
            next_slot = slot + 2'h1;
            if (slot == dsam_pkg::LAST_SLOT) begin
              next_dw_valid = 1'b1;
              next_dw       = full;
              next_dw_k     = kfull;
              next_dw_class = dsam_pkg::CL_PRIM;
              next_mode     = RX_ALIGNED;
              next_bad      = 1'b0;
            end
          end else begin
            next_slot = 2'h0;
          end
        end
        RX_ALIGNED: begin
          // Every four characters yield one classified dword.
          next_acc  = full;
          next_kacc = kfull;
          next_slot = slot + 2'h1;
          next_bad  = (slot == 2'h0) ? !chr_ok : (bad || !chr_ok);
          if (slot == dsam_pkg::LAST_SLOT) begin
            next_dw_valid = 1'b1;
            next_dw       = full;
            next_dw_k     = kfull;
            if (bad || !chr_ok)
              next_dw_class = dsam_pkg::CL_INVALID;
            else if (dsam_pkg::is_comma(full[31:24], kfull[3]) && kfull[2:0] == 3'h0)
              next_dw_class = dsam_pkg::CL_PRIM;
            else
              next_dw_class = dsam_pkg::CL_DATA;
          end
        end
        default: next_mode = mode;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode       <= RX_IDLE;
      slot       <= 2'h0;
      acc        <= 32'h00000000;
      kacc       <= 4'h0;
      bad        <= 1'b0;
      dw_valid_o <= 1'b0;
      dw_o       <= 32'h00000000;
      dw_k_o     <= 4'h0;
      dw_class_o <= dsam_pkg::CL_INVALID;
    end else begin
      mode       <= next_mode;
      slot       <= next_slot;
      acc        <= next_acc;
      kacc       <= next_kacc;
      bad        <= next_bad;
      dw_valid_o <= next_dw_valid;
      dw_o       <= next_dw;
      dw_k_o     <= next_dw_k;
      dw_class_o <= next_dw_class;
    end
  end

  default clocking dsam_rx_cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_prim_has_comma;
    dw_valid_o && dw_class_o == dsam_pkg::CL_PRIM |-> dw_k_o == 4'h8 &&
      dw_o[31:24] == dsam_pkg::COMMA_CHAR;
  endproperty
  a_prim_has_comma: assert property (p_prim_has_comma) else $error("primitive without comma");

  property p_find_silences;
    find_i |=> !dw_valid_o;
  endproperty
  a_find_silences: assert property (p_find_silences) else $error("dword after find");

endmodule : dsam_char_rx

// ### bench/dsam_seq_model.sv
// Stand-in for the phy reset sequencer: relays begin requests, tallies messages.
// Assumes the bench raises want_begin_i for one cycle, off the rising edge.
`timescale 1ns/1ps
module dsam_seq_model (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic want_begin_i,
  input  wire logic sync_lost_msg_i,
  input  wire logic sync_timeout_reset_msg_i,
  output logic      sync_begin_msg_o,
  output int        lost_seen,
  output int        reset_seen
);
  // Begin follows the request directly, so it is never late by a phase.
  assign sync_begin_msg_o = want_begin_i;
  // Every high cycle is tallied, so a stretched pulse shows up as an extra count.
  always @(posedge clock_i) begin
    if (srst_i) begin
      lost_seen <= 0;
      reset_seen <= 0;
    end else begin
      lost_seen <= lost_seen + int'(sync_lost_msg_i);
      reset_seen <= reset_seen + int'(sync_timeout_reset_msg_i);
    end
  end
endmodule : dsam_seq_model

// ### bench/tb_dsam_top.sv
// Self-checking bench for the dword sync block with a sequencer stand-in.
// Assumes a 25 MHz clock and a timeout shortened to 40 cycles.
`timescale 1ns/1ps
module tb_dsam_top;
  localparam logic [31:0] PRIM = 32'hBC4A4A27;
  localparam logic [31:0] DATA = 32'h12345678;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        cv = 1'b0, ck = 1'b0, cce = 1'b0, cde = 1'b0;
  logic [7:0]  ch = 8'h00;
  logic        want = 1'b0, halt = 1'b0, mgmt = 1'b0, dis = 1'b0;
  logic        beg, lost, tres, locked, lv;
  logic [31:0] ldw;
  logic [3:0]  lk;
  dsam_pkg::dsam_class_t lcl;
  int          lost_n, reset_n, fwd_n = 0, failures = 0, samples_checked = 0;

  always #20 clock_i = ~clock_i;

  dsam_top #(.TIMEOUT_CYC(40)) dsam_top_i (.clock_i(clock_i), .srst_i(srst_i),
    .char_valid_i(cv), .char_i(ch), .char_k_i(ck), .char_code_err_i(cce),
    .char_disp_err_i(cde), .sync_begin_msg_i(beg), .sync_halt_msg_i(halt),
    .mgmt_reset_req_i(mgmt), .disable_phy_req_i(dis), .sync_lost_msg_o(lost),
    .sync_timeout_reset_msg_o(tres), .sync_locked_o(locked), .link_dw_valid_o(lv),
    .link_dw_o(ldw), .link_dw_k_o(lk), .link_dw_class_o(lcl));
  dsam_seq_model dsam_seq_model_i (.clock_i(clock_i), .srst_i(srst_i),
    .want_begin_i(want), .sync_lost_msg_i(lost), .sync_timeout_reset_msg_i(tres),
    .sync_begin_msg_o(beg), .lost_seen(lost_n), .reset_seen(reset_n));

  // Forwarded dwords are counted as they pass, one per valid pulse.
  always @(posedge clock_i) begin
    if (lv === 1'b1) fwd_n <= fwd_n + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  // Four characters, first in the top byte, with per-character flags.
  task automatic send_dw(input logic [31:0] w, input logic [3:0] k,
                         input logic [3:0] ce, input logic [3:0] de);
    for (int i = 3; i >= 0; i--) begin
      @(negedge clock_i);
      cv = 1'b1;
      ch = w[8*i +: 8];
      ck = k[i];
      cce = ce[i];
      cde = de[i];
    end
    @(negedge clock_i);
    cv = 1'b0;
  endtask : send_dw

  task automatic begin_sync;
    @(negedge clock_i);
    want = 1'b1;
    @(negedge clock_i);
    want = 1'b0;
    cyc(3);
  endtask : begin_sync

  // The first comma carries a disparity error, which must not stop alignment.
  task automatic lock_up;
    begin_sync();
    send_dw(DATA, 4'h0, 4'h0, 4'h0);
    send_dw(PRIM, 4'h8, 4'h0, 4'h8);
    send_dw(PRIM, 4'h8, 4'h0, 4'h0);
    send_dw(PRIM, 4'h8, 4'h0, 4'h0);
    cyc(3);
  endtask : lock_up

  task automatic t_lock;
    int f0;
    f0 = fwd_n;
    lock_up();
    chk("locked", 1, locked);
    chk("fwd count", 1, fwd_n - f0);
    chk("fwd dword", PRIM, ldw);
    chk("fwd k flags", 4'h8, lk);
    chk("fwd class", dsam_pkg::CL_PRIM, lcl);
    $display("test lock done");
  endtask : t_lock

  // Nullification by two valid dwords, then four uncancelled invalid ones.
  task automatic t_loss;
    int f0;
    f0 = fwd_n;
    send_dw(DATA, 4'h0, 4'h2, 4'h0);
    send_dw(DATA, 4'h0, 4'h0, 4'h0);
    send_dw(DATA, 4'h0, 4'h0, 4'h0);
    cyc(2);
    chk("data dword", DATA, ldw);
    chk("data class", dsam_pkg::CL_DATA, lcl);
    for (int i = 0; i < 3; i++) send_dw(DATA, 4'h0, 4'h1, 4'h0);
    send_dw(DATA, 4'h0, 4'h0, 4'h0);
    chk("still locked", 1, locked);
    send_dw(DATA, 4'h0, 4'h4, 4'h0);
    cyc(3);
    chk("lost pulses", 1, lost_n);
    chk("unlocked", 0, locked);
    chk("fwd after loss", 7, fwd_n - f0);
    send_dw(DATA, 4'h0, 4'h0, 4'h0);
    cyc(3);
    chk("withheld", 7, fwd_n - f0);
    $display("test loss done");
  endtask : t_loss

  // An invalid dword in the first valid state refinds without a timer reload.
  task automatic t_timeout;
    begin_sync();
    send_dw(PRIM, 4'h8, 4'h0, 4'h0);
    send_dw(DATA, 4'h0, 4'h8, 4'h0);
    cyc(15);
    chk("no early reset", 0, reset_n);
    cyc(25);
    chk("reset pulses", 1, reset_n);
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_stop;
    int f0;
    for (int i = 0; i < 3; i++) begin
      lock_up();
      @(negedge clock_i);
      halt = (i == 0);
      mgmt = (i == 1);
      dis = (i == 2);
      @(negedge clock_i);
      {halt, mgmt, dis} = 3'h0;
      cyc(2);
      chk("stopped", 0, locked);
      f0 = fwd_n;
      send_dw(PRIM, 4'h8, 4'h0, 4'h0);
      cyc(3);
      chk("no fwd stopped", f0, fwd_n);
    end
    $display("test stop done");
  endtask : t_stop

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // The tests need well under a thousand cycles; this limit is ten times that.
  initial begin
    #400000;
    failures++;
    final_report();
  end

  initial begin
    cyc(3);
    srst_i = 1'b0;
    t_lock();
    t_loss();
    t_timeout();
    t_stop();
    final_report();
  end
endmodule : tb_dsam_top
